// [logic/vdm_resp_pkg.sv]
// Purpose: shared types and constants for the structured message responder
// Assumes: one clock, active-low asynchronous reset
// Notes:   command and answer codes are local encodings of this block
package vdm_resp_pkg;

    // request kinds taken from the message layer
    typedef enum logic [2:0] {
        CMD_NONE     = 3'h0,
        CMD_IDENTITY = 3'h1,
        CMD_SVIDS    = 3'h2,
        CMD_MODES    = 3'h3,
        CMD_ENTER    = 3'h4,
        CMD_EXIT     = 3'h5
    } vdm_cmd_t;

    // answer kinds sent back to the partner
    typedef enum logic [1:0] {
        ANS_ACK  = 2'h0,
        ANS_NAK  = 2'h1,
        ANS_BUSY = 2'h2
    } vdm_ans_t;

    // request from the message layer
    typedef struct packed {
        logic     valid;
        vdm_cmd_t cmd;
    } vdm_req_t;

    // decision from the policy manager
    typedef struct packed {
        logic     valid;
        vdm_ans_t ans;
    } pm_reply_t;

    // response handed to the message layer
    typedef struct packed {
        logic     valid;
        vdm_cmd_t cmd;
        vdm_ans_t ans;
    } vdm_rsp_t;

    localparam logic READY_SOURCE = 1'b0;
    localparam logic READY_SINK   = 1'b1;

endpackage : vdm_resp_pkg

// [logic/ready_origin.sv]
// Purpose: remembers which ready state a request was taken from
// Assumes: capture is high while the engine sits in a ready state
// Notes:   holds value until the next capture
`timescale 1ns/1ns
module ready_origin
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic capture,
    input  wire logic sink_now,
    output logic      origin_sink
);
    logic origin_q;

    // latch power role at request acceptance
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            origin_q <= vdm_resp_pkg::READY_SOURCE;
        else if (capture)
            origin_q <= sink_now;
    end

    assign origin_sink = origin_q;

endmodule : ready_origin

// [logic/ufp_vdm_responder.sv]
// Purpose: responder engine for discover, enter and exit requests from the DFP
// Assumes: message layer and policy manager run on clk; pulses last one cycle
// Notes:   one request handled at a time; busy ignores new requests
// Behaviour
// - handle all five request kinds
// - identity request: gather, ask policy manager
// - identity info given: send identity ACK
// - after identity ACK, return to origin ready
// - identity NAK/BUSY: send it, return ready
// - SVID request: gather, ask policy manager
// - SVID info given: send ACK, return
// - SVID NAK/BUSY: send it, return ready
// - modes request: ask; NAK/BUSY sent, return
// - modes info given: send modes ACK
// - after modes ACK, return to ready
// - enter request: ask evaluation and entry
// - mode entered: send enter ACK
// - after enter ACK, return to origin
// - entry rejected: send NAK, return ready
// - grant entry only in USB or safe state
// - exit request: ask to leave mode
// - mode left: send exit ACK, return
// - exit NAK: send NAK, return ready
`timescale 1ns/1ns
module ufp_vdm_responder
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   sink_role,
    input  wire logic                   usb_safe_ok,
    input  wire vdm_resp_pkg::vdm_req_t req,
    output logic                        req_ready,
    output vdm_resp_pkg::vdm_cmd_t      pm_ask,
    output logic                        pm_ask_valid,
    input  wire vdm_resp_pkg::pm_reply_t pm_reply,
    output vdm_resp_pkg::vdm_rsp_t      rsp,
    input  wire logic                   rsp_sent,
    output logic                        source_ready,
    output logic                        sink_ready
);
    typedef enum {
        READY_ST,
        IDENTITY_GATHER_STATE,
        IDENTITY_ACK_STATE,
        IDENTITY_REFUSE_STATE,
        SVID_GATHER_STATE,
        SVID_ACK_STATE,
        SVID_REFUSE_STATE,
        MODES_GATHER_STATE,
        MODES_ACK_STATE,
        MODES_REFUSE_STATE,
        MODE_ENTRY_EVALUATE_STATE,
        MODE_ENTRY_ACK_STATE,
        MODE_ENTRY_REFUSE_STATE,
        MODE_LEAVE_EVALUATE_STATE,
        MODE_LEAVE_ACK_STATE,
        MODE_LEAVE_REFUSE_STATE
    } state_t;

    state_t                 state_q;
    state_t                 state_d;
    vdm_resp_pkg::vdm_ans_t ans_q;
    vdm_resp_pkg::vdm_ans_t ans_d;
    vdm_resp_pkg::vdm_rsp_t rsp_q;
    vdm_resp_pkg::vdm_rsp_t rsp_d;
    logic                   origin_sink;

    // named decodes
    wire in_ready   = (state_q == READY_ST);
    wire take_req   = in_ready && req.valid && (req.cmd != vdm_resp_pkg::CMD_NONE);
    wire reply_ack  = pm_reply.valid && (pm_reply.ans == vdm_resp_pkg::ANS_ACK);
    wire reply_ref  = pm_reply.valid && (pm_reply.ans != vdm_resp_pkg::ANS_ACK);
    wire reply_nak  = pm_reply.valid && (pm_reply.ans == vdm_resp_pkg::ANS_NAK);
    wire gathering  = (state_q == IDENTITY_GATHER_STATE) || (state_q == SVID_GATHER_STATE)
                   || (state_q == MODES_GATHER_STATE) || (state_q == MODE_ENTRY_EVALUATE_STATE)
                   || (state_q == MODE_LEAVE_EVALUATE_STATE);
    wire sending    = !in_ready && !gathering;

    // request gate and ready flags; role frozen while a request runs
    assign req_ready    = in_ready;
    assign source_ready = in_ready && !origin_sink;
    assign sink_ready   = in_ready && origin_sink;
    assign rsp          = rsp_q;

    // tracks the role while ready, holds it from request acceptance on
    ready_origin u_origin
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .capture     (in_ready),
        .sink_now    (sink_role),
        .origin_sink (origin_sink)
    );

    // question to the policy manager while gathering or evaluating
    always_comb
    begin
        pm_ask_valid = gathering;
        case (state_q)
            IDENTITY_GATHER_STATE:     pm_ask = vdm_resp_pkg::CMD_IDENTITY;
            SVID_GATHER_STATE:         pm_ask = vdm_resp_pkg::CMD_SVIDS;
            MODES_GATHER_STATE:        pm_ask = vdm_resp_pkg::CMD_MODES;
            MODE_ENTRY_EVALUATE_STATE: pm_ask = vdm_resp_pkg::CMD_ENTER;
            MODE_LEAVE_EVALUATE_STATE: pm_ask = vdm_resp_pkg::CMD_EXIT;
            default:                   pm_ask = vdm_resp_pkg::CMD_NONE;
        endcase
    end

    // next state
    always_comb
    begin
        state_d = state_q;
        ans_d   = ans_q;
        case (state_q)
            READY_ST:
            begin
                if (take_req)
                begin
                    case (req.cmd)
                        vdm_resp_pkg::CMD_IDENTITY: state_d = IDENTITY_GATHER_STATE;
                        vdm_resp_pkg::CMD_SVIDS:    state_d = SVID_GATHER_STATE;
                        vdm_resp_pkg::CMD_MODES:    state_d = MODES_GATHER_STATE;
                        vdm_resp_pkg::CMD_ENTER:    state_d = MODE_ENTRY_EVALUATE_STATE;
                        vdm_resp_pkg::CMD_EXIT:     state_d = MODE_LEAVE_EVALUATE_STATE;
                        default:                    state_d = READY_ST;
                    endcase
                end
            end
            IDENTITY_GATHER_STATE:
            begin
                if (reply_ack)
                    state_d = IDENTITY_ACK_STATE;
                else if (reply_ref)
                begin
                    state_d = IDENTITY_REFUSE_STATE;
                    ans_d   = pm_reply.ans;
                end
            end
            SVID_GATHER_STATE:
            begin
                if (reply_ack)
                    state_d = SVID_ACK_STATE;
                else if (reply_ref)
                begin
                    state_d = SVID_REFUSE_STATE;
                    ans_d   = pm_reply.ans;
                end
            end
            MODES_GATHER_STATE:
            begin
                if (reply_ack)
                    state_d = MODES_ACK_STATE;
                else if (reply_ref)
                begin
                    state_d = MODES_REFUSE_STATE;
                    ans_d   = pm_reply.ans;
                end
            end
            MODE_ENTRY_EVALUATE_STATE:
            begin
                // entry only granted from USB operation or safe state
                if (reply_ack && usb_safe_ok)
                    state_d = MODE_ENTRY_ACK_STATE;
                else if (pm_reply.valid)
                begin
                    state_d = MODE_ENTRY_REFUSE_STATE;
                    ans_d   = vdm_resp_pkg::ANS_NAK;
                end
            end
            MODE_LEAVE_EVALUATE_STATE:
            begin
                if (reply_ack)
                    state_d = MODE_LEAVE_ACK_STATE;
                else if (reply_nak)
                begin
                    state_d = MODE_LEAVE_REFUSE_STATE;
                    ans_d   = vdm_resp_pkg::ANS_NAK;
                end
            end
            IDENTITY_ACK_STATE, IDENTITY_REFUSE_STATE,
            SVID_ACK_STATE, SVID_REFUSE_STATE,
            MODES_ACK_STATE, MODES_REFUSE_STATE,
            MODE_ENTRY_ACK_STATE, MODE_ENTRY_REFUSE_STATE,
            MODE_LEAVE_ACK_STATE, MODE_LEAVE_REFUSE_STATE:
            begin
                if (rsp_sent)
                    state_d = READY_ST;
            end
            default: state_d = READY_ST;
        endcase
    end

    // response word built on entry to a sending state
    always_comb
    begin
        rsp_d = rsp_q;
        rsp_d.valid = 1'b0;
        case (state_d)
            IDENTITY_ACK_STATE, IDENTITY_REFUSE_STATE:
                rsp_d.cmd = vdm_resp_pkg::CMD_IDENTITY;
            SVID_ACK_STATE, SVID_REFUSE_STATE:
                rsp_d.cmd = vdm_resp_pkg::CMD_SVIDS;
            MODES_ACK_STATE, MODES_REFUSE_STATE:
                rsp_d.cmd = vdm_resp_pkg::CMD_MODES;
            MODE_ENTRY_ACK_STATE, MODE_ENTRY_REFUSE_STATE:
                rsp_d.cmd = vdm_resp_pkg::CMD_ENTER;
            MODE_LEAVE_ACK_STATE, MODE_LEAVE_REFUSE_STATE:
                rsp_d.cmd = vdm_resp_pkg::CMD_EXIT;
            default:
                rsp_d.cmd = vdm_resp_pkg::CMD_NONE;
        endcase
        if (rsp_d.cmd != vdm_resp_pkg::CMD_NONE)
        begin
            rsp_d.valid = !(state_q == state_d && rsp_sent);
            rsp_d.ans   = (state_d == IDENTITY_ACK_STATE || state_d == SVID_ACK_STATE
                        || state_d == MODES_ACK_STATE || state_d == MODE_ENTRY_ACK_STATE
                        || state_d == MODE_LEAVE_ACK_STATE) ? vdm_resp_pkg::ANS_ACK : ans_d;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= READY_ST;
            ans_q   <= vdm_resp_pkg::ANS_ACK;
            rsp_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            ans_q   <= ans_d;
            rsp_q   <= rsp_d;
        end
    end

    // helper: origin must still match at return to ready
    logic was_sending_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            was_sending_q <= 1'b0;
        else
            was_sending_q <= sending && rsp_sent;
    end

    // helper: role seen when the request was taken
    logic role_at_take_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            role_at_take_q <= vdm_resp_pkg::READY_SOURCE;
        else if (take_req)
            role_at_take_q <= sink_role;
    end

    a_ready_return: assert property (@(posedge clk) disable iff (!rst_b)
        (sending && rsp_sent) |=> in_ready)
        else $error("no return to ready after response sent");
    a_origin_kept: assert property (@(posedge clk) disable iff (!rst_b)
        was_sending_q |-> (sink_ready == role_at_take_q) && (source_ready == !role_at_take_q))
        else $error("ready state differs from origin");
    a_identity_gather: assert property (@(posedge clk) disable iff (!rst_b)
        (take_req && req.cmd == vdm_resp_pkg::CMD_IDENTITY) |=>
        (pm_ask_valid && pm_ask == vdm_resp_pkg::CMD_IDENTITY))
        else $error("identity request not forwarded");
    a_identity_ack: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == IDENTITY_GATHER_STATE && reply_ack) |=>
        (rsp.valid && rsp.ans == vdm_resp_pkg::ANS_ACK && rsp.cmd == vdm_resp_pkg::CMD_IDENTITY))
        else $error("identity ACK missing");
    a_svid_refuse: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == SVID_GATHER_STATE && reply_ref) |=>
        (rsp.valid && rsp.ans == $past(pm_reply.ans)))
        else $error("SVID refusal kind wrong");
    a_modes_ask: assert property (@(posedge clk) disable iff (!rst_b)
        (take_req && req.cmd == vdm_resp_pkg::CMD_MODES) |=> pm_ask == vdm_resp_pkg::CMD_MODES)
        else $error("modes request not forwarded");
    a_modes_ack: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == MODES_GATHER_STATE && reply_ack) |=> state_q == MODES_ACK_STATE)
        else $error("modes ACK state missed");
    a_entry_unsafe: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == MODE_ENTRY_EVALUATE_STATE && pm_reply.valid && !usb_safe_ok) |=>
        (rsp.ans == vdm_resp_pkg::ANS_NAK))
        else $error("entry acked outside safe state");
    a_exit_nak: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == MODE_LEAVE_EVALUATE_STATE && reply_nak) |=>
        (rsp.valid && rsp.cmd == vdm_resp_pkg::CMD_EXIT && rsp.ans == vdm_resp_pkg::ANS_NAK))
        else $error("exit NAK missing");
    a_single_req: assert property (@(posedge clk) disable iff (!rst_b)
        (!in_ready && req.valid && !pm_reply.valid && !rsp_sent) |=> state_q == $past(state_q))
        else $error("request accepted while busy");
    a_rsp_held: assert property (@(posedge clk) disable iff (!rst_b)
        (rsp.valid && !rsp_sent) |=> rsp.valid)
        else $error("response dropped before it was sent");
    a_exit_busy_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == MODE_LEAVE_EVALUATE_STATE && pm_reply.valid
        && pm_reply.ans == vdm_resp_pkg::ANS_BUSY) |=>
        (pm_ask_valid && pm_ask == vdm_resp_pkg::CMD_EXIT))
        else $error("exit request dropped on busy answer");

    c_enter_ack: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == MODE_ENTRY_ACK_STATE ##1 in_ready);
    c_identity_busy: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == IDENTITY_REFUSE_STATE && rsp.ans == vdm_resp_pkg::ANS_BUSY);
    c_exit_ack: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == MODE_LEAVE_ACK_STATE && rsp_sent);
    c_modes_refuse: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == MODES_REFUSE_STATE ##1 in_ready);
    c_entry_unsafe: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == MODE_ENTRY_EVALUATE_STATE && pm_reply.valid && !usb_safe_ok);

endmodule : ufp_vdm_responder

// [sim/pm_model.sv]
// Purpose: policy manager and message layer stand-in facing the responder
// Assumes: decisions and send-done come as one-cycle pulses after a set delay
// Notes:   released answer field carries the inverted answer, never the last value
`timescale 1ns/1ns
module pm_model
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   pm_ask_valid,
    input  wire vdm_resp_pkg::vdm_ans_t reply_ans,
    input  wire logic [3:0]             wait_cycles,
    output vdm_resp_pkg::pm_reply_t     pm_reply,
    input  wire vdm_resp_pkg::vdm_rsp_t rsp,
    output logic                        rsp_sent
);
    logic [3:0] ask_cnt_q;
    logic [3:0] send_cnt_q;
    logic       ask_hit;
    logic       send_hit;

    // decide once the delay has run out, one pulse per wait
    assign ask_hit  = pm_ask_valid && !pm_reply.valid && (ask_cnt_q == wait_cycles);
    assign send_hit = rsp.valid && !rsp_sent && (send_cnt_q == wait_cycles);

    // delay counters and pulse outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ask_cnt_q  <= 4'h0;
            send_cnt_q <= 4'h0;
            pm_reply   <= '0;
            rsp_sent   <= 1'b0;
        end
        else
        begin
            ask_cnt_q      <= (pm_ask_valid && !ask_hit) ? ask_cnt_q + 4'h1 : 4'h0;
            send_cnt_q     <= (rsp.valid && !send_hit) ? send_cnt_q + 4'h1 : 4'h0;
            pm_reply.valid <= ask_hit;
            pm_reply.ans   <= ask_hit ? reply_ans : vdm_resp_pkg::vdm_ans_t'(~reply_ans);
            rsp_sent       <= send_hit;
        end
    end
endmodule : pm_model

// [sim/ufp_vdm_responder_test.sv]
// Purpose: self-checking bench for the structured message responder
// Assumes: partner model answers after wait_cycles; inputs launched at rising edges
// Notes:   every request kind and answer kind is walked; entry in sink role, exit in source role, discover in source role, modes also in sink role
`timescale 1ns/1ns
module ufp_vdm_responder_test;
    logic                    clk;
    logic                    rst_b;
    logic                    sink_role;
    logic                    usb_safe_ok;
    vdm_resp_pkg::vdm_req_t  req;
    logic                    req_ready;
    vdm_resp_pkg::vdm_cmd_t  pm_ask;
    logic                    pm_ask_valid;
    vdm_resp_pkg::pm_reply_t pm_reply;
    vdm_resp_pkg::vdm_rsp_t  rsp;
    logic                    rsp_sent;
    logic                    source_ready;
    logic                    sink_ready;
    vdm_resp_pkg::vdm_ans_t  reply_ans;
    logic [3:0]              wait_cycles;
    int                      bad_count;
    int                      tests_run;

    ufp_vdm_responder i_ufp_vdm_responder (.clk(clk), .rst_b(rst_b), .sink_role(sink_role),
        .usb_safe_ok(usb_safe_ok), .req(req), .req_ready(req_ready), .pm_ask(pm_ask),
        .pm_ask_valid(pm_ask_valid), .pm_reply(pm_reply), .rsp(rsp), .rsp_sent(rsp_sent),
        .source_ready(source_ready), .sink_ready(sink_ready));

    pm_model i_pm_model (.clk(clk), .rst_b(rst_b), .pm_ask_valid(pm_ask_valid),
        .reply_ans(reply_ans), .wait_cycles(wait_cycles), .pm_reply(pm_reply), .rsp(rsp),
        .rsp_sent(rsp_sent));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // code compare
    task automatic chk_code(input string what, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_code

    // flag compare
    task automatic chk_flag(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    // one request through ask, answer, send and back to ready
    task automatic do_req(input vdm_resp_pkg::vdm_cmd_t c, input vdm_resp_pkg::vdm_ans_t a,
                          input vdm_resp_pkg::vdm_ans_t e);
        int   n;
        logic role;
        @(posedge clk);
        role      = sink_role;
        reply_ans <= a;
        req       <= '{1'b1, c};
        @(posedge clk);
        req <= '{1'b0, vdm_resp_pkg::CMD_NONE};
        #1;
        chk_flag("ask_valid", 1'b1, pm_ask_valid);
        chk_code("ask_kind", c, pm_ask);
        chk_flag("busy_ready", 1'b0, req_ready);
        n = 0;
        while (rsp.valid !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_code("rsp_kind", c, rsp.cmd);
        chk_code("rsp_ans", {1'b0, e}, {1'b0, rsp.ans});
        while (rsp.valid === 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag("ready", 1'b1, req_ready);
        chk_flag("sink_ready", role, sink_ready);
        chk_flag("source_ready", !role, source_ready);
    endtask : do_req

    // discover kinds with every answer, source role
    task automatic s_discover();
        @(posedge clk);
        sink_role <= 1'b0;
        for (int k = 1; k <= 3; k++)
            for (int j = 0; j <= 2; j++)
            begin
                wait_cycles <= 4'(j * 3);
                do_req(vdm_resp_pkg::vdm_cmd_t'(k), vdm_resp_pkg::vdm_ans_t'(j),
                       vdm_resp_pkg::vdm_ans_t'(j));
            end
    endtask : s_discover

    // mode entry accepted, refused, and refused for unsafe state, sink role
    task automatic s_enter();
        @(posedge clk);
        sink_role   <= 1'b1;
        usb_safe_ok <= 1'b1;
        wait_cycles <= 4'h1;
        do_req(vdm_resp_pkg::CMD_ENTER, vdm_resp_pkg::ANS_ACK, vdm_resp_pkg::ANS_ACK);
        do_req(vdm_resp_pkg::CMD_ENTER, vdm_resp_pkg::ANS_NAK, vdm_resp_pkg::ANS_NAK);
        do_req(vdm_resp_pkg::CMD_ENTER, vdm_resp_pkg::ANS_BUSY, vdm_resp_pkg::ANS_NAK);
        @(posedge clk);
        usb_safe_ok <= 1'b0;
        do_req(vdm_resp_pkg::CMD_ENTER, vdm_resp_pkg::ANS_ACK, vdm_resp_pkg::ANS_NAK);
        @(posedge clk);
        usb_safe_ok <= 1'b1;
    endtask : s_enter

    // mode exit left, refused, and held over busy answers
    task automatic s_exit();
        @(posedge clk);
        sink_role   <= 1'b0;
        wait_cycles <= 4'h2;
        do_req(vdm_resp_pkg::CMD_EXIT, vdm_resp_pkg::ANS_ACK, vdm_resp_pkg::ANS_ACK);
        do_req(vdm_resp_pkg::CMD_EXIT, vdm_resp_pkg::ANS_NAK, vdm_resp_pkg::ANS_NAK);
        fork
            do_req(vdm_resp_pkg::CMD_EXIT, vdm_resp_pkg::ANS_BUSY, vdm_resp_pkg::ANS_ACK);
            begin
                repeat (14) @(posedge clk);
                reply_ans <= vdm_resp_pkg::ANS_ACK;
                #1;
                chk_flag("exit_wait", 1'b0, rsp.valid);
                chk_flag("exit_asking", 1'b1, pm_ask_valid);
            end
        join
    endtask : s_exit

    // second request offered while busy is ignored
    task automatic s_refuse();
        @(posedge clk);
        wait_cycles <= 4'h9;
        fork
            do_req(vdm_resp_pkg::CMD_SVIDS, vdm_resp_pkg::ANS_ACK, vdm_resp_pkg::ANS_ACK);
            begin
                repeat (5) @(posedge clk);
                req <= '{1'b1, vdm_resp_pkg::CMD_MODES};
                @(posedge clk);
                req <= '{1'b0, vdm_resp_pkg::CMD_NONE};
            end
        join
        repeat (3) @(posedge clk);
        #1;
        chk_flag("no_second", 1'b0, pm_ask_valid);
    endtask : s_refuse

    // role flips mid-request: return to the origin, then follow the new role
    task automatic s_origin();
        @(posedge clk);
        sink_role   <= 1'b1;
        wait_cycles <= 4'h4;
        fork
            do_req(vdm_resp_pkg::CMD_MODES, vdm_resp_pkg::ANS_ACK, vdm_resp_pkg::ANS_ACK);
            begin
                repeat (4) @(posedge clk);
                sink_role <= 1'b0;
            end
        join
        @(posedge clk);
        #1;
        chk_flag("role_follow_sink", 1'b0, sink_ready);
        chk_flag("role_follow_source", 1'b1, source_ready);
    endtask : s_origin

    // verdict and stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // hang guard, well beyond the expected run
    initial
    begin
        #(20 * 5000);
        bad_count++;
        end_of_test();
    end

    // reset, then the scenarios
    initial
    begin
        bad_count   = 0;
        tests_run   = 0;
        rst_b       = 1'b0;
        sink_role   = 1'b0;
        usb_safe_ok = 1'b1;
        req         = '0;
        reply_ans   = vdm_resp_pkg::ANS_ACK;
        wait_cycles = 4'h0;
        repeat (3) @(posedge clk);
        #1;
        chk_flag("reset_ready", 1'b1, req_ready);
        chk_flag("reset_source", 1'b1, source_ready);
        chk_flag("reset_rsp", 1'b0, rsp.valid);
        @(posedge clk);
        rst_b <= 1'b1;
        s_discover();
        s_enter();
        s_exit();
        s_refuse();
        s_origin();
        end_of_test();
    end
endmodule : ufp_vdm_responder_test
